/* shared/phy_gig_status_regs.vh */
// Register offsets, field positions, reset values of the gigabit status bank.
// Included by the MDIO slave and the register bank; definitions only.
`ifndef PHY_GIG_STATUS_REGS_VH
`define PHY_GIG_STATUS_REGS_VH

// ==========================================================
// Register offsets (5-bit MDIO register address; DIRECT_TOP_ADDR is 16 bits)
`define GIG_LINK_STATUS_ADDR 5'h0A
`define IND_CTRL_ADDR 5'h0D
`define IND_ADDR_DATA_ADDR 5'h0E
`define GIG_ABILITY_ADDR 5'h0F
`define DIRECT_TOP_ADDR 16'h001F

// ==========================================================
// Field positions
`define STS_FAULT_BIT 15
`define STS_MASTER_BIT 14
`define STS_LOCAL_RX_BIT 13
`define STS_REMOTE_RX_BIT 12
`define STS_LP_FD_BIT 11
`define STS_LP_HD_BIT 10
`define CTRL_FUNC_HI 15
`define CTRL_FUNC_LO 14
`define CTRL_DEV_HI 4
`define CTRL_DEV_LO 0

// ==========================================================
// Function codes and target device
`define FUNC_ADDRESS 2'h0
`define FUNC_DATA 2'h1
`define FUNC_DATA_INC_RW 2'h2
`define FUNC_DATA_INC_WR 2'h3
`define TARGET_DEVICE 5'h1F

// ==========================================================
// Reset values and idle count limit
`define CTRL_RESET 16'h0000
`define POINTER_RESET 16'h0000
`define ABILITY_RESET 16'h3000
`define IDLE_COUNT_MAX 8'hFF

// ==========================================================
// MDIO frame timing in management clock enables
`define MDIO_FRAME_BITS 6'h20
`define MDC_DIV 8'h04

`endif

/* rtl/mdio_frame_slave.v */
// MDIO clause 22 frame slave: decodes frames, raises read/write strobes.
// Assumes MDC is sampled synchronously to i_clk_sys.
`timescale 1ns/1ps
`include "phy_gig_status_regs.vh"

module mdio_frame_slave (
    input wire i_clk_sys,
    input wire i_sys_rst,
    input wire i_mdc,
    input wire i_mdio_in,
    input wire [4:0] i_phy_addr,
    input wire [15:0] i_rd_data,
    output reg o_mdio_out,
    output reg o_mdio_oe,
    output reg o_rd_stb,
    output reg o_wr_stb,
    output reg [4:0] o_reg_addr,
    output reg [15:0] o_wr_data
);

// ==========================================================
// Frame states
localparam ST_IDLE = 4'b0001;
localparam ST_HEAD = 4'b0010;
localparam ST_READ = 4'b0100;
localparam ST_WRITE = 4'b1000;

reg [3:0] state;
reg mdc_q;
reg [5:0] ones;
reg [5:0] cnt;
reg [13:0] head;
reg [15:0] shift;
reg mine;
wire rise;
wire fall;

assign rise = i_mdc & ~mdc_q;
assign fall = ~i_mdc & mdc_q;

// ==========================================================
// Frame decoder
always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        state <= ST_IDLE;
        mdc_q <= 1'b0;
        ones <= 6'h00;
        cnt <= 6'h00;
        head <= 14'h0000;
        shift <= 16'h0000;
        mine <= 1'b0;
        o_mdio_out <= 1'b1;
        o_mdio_oe <= 1'b0;
        o_rd_stb <= 1'b0;
        o_wr_stb <= 1'b0;
        o_reg_addr <= 5'h00;
        o_wr_data <= 16'h0000;
    end else begin
        mdc_q <= i_mdc;
        o_rd_stb <= 1'b0;
        o_wr_stb <= 1'b0;
        case (state)
            ST_IDLE: begin
                o_mdio_oe <= 1'b0;
                if (rise) begin
                    // Preamble of 32 ones, then start bit zero
                    if (i_mdio_in) begin
                        if (ones != `MDIO_FRAME_BITS)
                            ones <= ones + 6'h01;
                    end else begin
                        if (ones == `MDIO_FRAME_BITS) begin
                            state <= ST_HEAD;
                            cnt <= 6'h00;
                        end
                        ones <= 6'h00;
                    end
                end
            end
            ST_HEAD: begin
                if (rise) begin
                    head <= {head[12:0], i_mdio_in};
                    cnt <= cnt + 6'h01;
                    // ST low bit, OP(2), PHYAD(5), REGAD(5) = 13 bits
                    if (cnt == 6'h0C) begin
                        o_reg_addr <= {head[3:0], i_mdio_in};
                        mine <= (head[8:4] == i_phy_addr);
                        cnt <= 6'h00;
                        // head[11] is the start bit, op sits in 10:9
                        if (head[10:9] == 2'b10) begin
                            state <= ST_READ;
                            o_rd_stb <= (head[8:4] == i_phy_addr);
                        end else if (head[10:9] == 2'b01)
                            state <= ST_WRITE;
                        else
                            state <= ST_IDLE;
                    end
                end
            end
            ST_READ: begin
                if (o_rd_stb)
                    shift <= i_rd_data;
                if (fall) begin
                    cnt <= cnt + 6'h01;
                    // Turnaround: float first, drive zero second
                    // Frames for another address keep the idle high level
                    if (cnt == 6'h01) begin
                        o_mdio_oe <= mine;
                        o_mdio_out <= ~mine;
                    end else if (cnt >= 6'h02 && cnt <= 6'h11) begin
                        o_mdio_out <= shift[15] | ~mine;
                        shift <= {shift[14:0], 1'b0};
                    end else if (cnt == 6'h12) begin
                        o_mdio_oe <= 1'b0;
                        o_mdio_out <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
            end
            ST_WRITE: begin
                if (rise) begin
                    cnt <= cnt + 6'h01;
                    if (cnt >= 6'h02)
                        shift <= {shift[14:0], i_mdio_in};
                    if (cnt == 6'h11) begin
                        o_wr_data <= {shift[14:0], i_mdio_in};
                        o_wr_stb <= mine;
                        state <= ST_IDLE;
                    end
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

endmodule

/* rtl/phy_gig_status_indirect_regs.v */
// Gigabit link status, ability and indirect extended-register access bank.
// Assumes MDC/MDIO and all status inputs are synchronous to i_clk_sys;
// the extended register store lives outside, reached by the ext_ ports.
//
// Functional notes
// - Fault bit 15 latches high, clears on read
// - Bit 14 shows master or slave resolution
// - Bits 13/12 show local, remote receiver OK
// - Bits 11/10 show partner full, half duplex
// - Reserved status and ability bits read zero
// - Idle error count in 7:0, cleared by read
// - Extended set reached only via 0x0D/0x0E
// - Function 00: data-port write loads pointer
// - Function 01: access pointed register, pointer holds
// - Function 10: access, then pointer increments always
// - Function 11: increment after writes only
// - Indirect access needs target field 11111
// - Control bits 13:5 ignore writes, read zero
// - 1000BASE-X ability bits 15/14 reset zero
// - 1000BASE-T ability bits 13/12 default one
`timescale 1ns/1ps
`include "phy_gig_status_regs.vh"

module phy_gig_status_indirect_regs (
    input wire i_clk_sys,
    input wire i_sys_rst,
    input wire i_mdc,
    input wire i_mdio_in,
    input wire [4:0] i_phy_addr,
    input wire i_ms_fault_event,
    input wire i_ms_resolved_master,
    input wire i_local_rx_ok,
    input wire i_remote_rx_ok,
    input wire i_lp_1000t_fd,
    input wire i_lp_1000t_hd,
    input wire i_idle_error_event,
    input wire [15:0] i_ext_rd_data,
    output reg o_mdio_out,
    output reg o_mdio_oe,
    output reg o_ext_rd_stb,
    output reg o_ext_wr_stb,
    output reg [15:0] o_ext_addr,
    output reg [15:0] o_ext_wr_data
);

// ==========================================================
// Frame slave
wire rd_stb;
wire wr_stb;
wire [4:0] reg_addr;
wire [15:0] wr_data;
wire frame_out;
wire frame_oe;
reg [15:0] rd_data;

mdio_frame_slave u_frame (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_mdc(i_mdc),
    .i_mdio_in(i_mdio_in),
    .i_phy_addr(i_phy_addr),
    .i_rd_data(rd_data),
    .o_mdio_out(frame_out),
    .o_mdio_oe(frame_oe),
    .o_rd_stb(rd_stb),
    .o_wr_stb(wr_stb),
    .o_reg_addr(reg_addr),
    .o_wr_data(wr_data)
);

// ==========================================================
// Decode helpers
function is_addr;
    input [4:0] a;
    input [4:0] b;
    begin
        is_addr = (a == b);
    end
endfunction

function [15:0] bump;
    input [15:0] p;
    begin
        bump = p + 16'h0001;
    end
endfunction

// ==========================================================
// State
reg ms_fault;
reg [7:0] idle_count;
reg [1:0] func_sel;
reg [4:0] target_dev;
reg [15:0] pointer;
wire target_ok;
wire data_rd;
wire data_wr;
wire sts_rd;

// Extended accesses honoured only for the vendor target
assign target_ok = (target_dev == `TARGET_DEVICE);
assign sts_rd = rd_stb & is_addr(reg_addr, `GIG_LINK_STATUS_ADDR);
assign data_rd = rd_stb & is_addr(reg_addr, `IND_ADDR_DATA_ADDR);
assign data_wr = wr_stb & is_addr(reg_addr, `IND_ADDR_DATA_ADDR);

// ==========================================================
// Read mux, combinational so the frame slave samples it same cycle
always @* begin
    rd_data = 16'h0000;
    case (reg_addr)
        `GIG_LINK_STATUS_ADDR: begin
            rd_data[`STS_FAULT_BIT] = ms_fault;
            rd_data[`STS_MASTER_BIT] = i_ms_resolved_master;
            rd_data[`STS_LOCAL_RX_BIT] = i_local_rx_ok;
            rd_data[`STS_REMOTE_RX_BIT] = i_remote_rx_ok;
            rd_data[`STS_LP_FD_BIT] = i_lp_1000t_fd;
            rd_data[`STS_LP_HD_BIT] = i_lp_1000t_hd;
            rd_data[7:0] = idle_count;
        end
        `IND_CTRL_ADDR: begin
            // Bits 13:5 stay zero
            rd_data[`CTRL_FUNC_HI:`CTRL_FUNC_LO] = func_sel;
            rd_data[`CTRL_DEV_HI:`CTRL_DEV_LO] = target_dev;
        end
        `IND_ADDR_DATA_ADDR: begin
            if (func_sel == `FUNC_ADDRESS)
                rd_data = pointer;
            else if (target_ok)
                rd_data = i_ext_rd_data;
            else
                rd_data = 16'h0000;
        end
        `GIG_ABILITY_ADDR: begin
            // Constant ability word, reserved low bits zero
            rd_data = `ABILITY_RESET;
        end
        default: rd_data = 16'h0000;
    endcase
end

// ==========================================================
// Clear-on-read status fields
always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        ms_fault <= 1'b0;
        idle_count <= 8'h00;
    end else begin
        // Event wins over the read clear so nothing is lost
        if (i_ms_fault_event)
            ms_fault <= 1'b1;
        else if (sts_rd)
            ms_fault <= 1'b0;
        if (sts_rd)
            idle_count <= {7'h00, i_idle_error_event};
        else if (i_idle_error_event && idle_count != `IDLE_COUNT_MAX)
            idle_count <= idle_count + 8'h01; // Saturates, no wrap
    end
end

// ==========================================================
// Control register and pointer
always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        func_sel <= 2'h0;
        target_dev <= 5'h00;
        pointer <= `POINTER_RESET;
    end else begin
        if (wr_stb && is_addr(reg_addr, `IND_CTRL_ADDR)) begin
            func_sel <= wr_data[`CTRL_FUNC_HI:`CTRL_FUNC_LO];
            target_dev <= wr_data[`CTRL_DEV_HI:`CTRL_DEV_LO];
        end
        if (target_ok) begin
            case (func_sel)
                `FUNC_ADDRESS: begin
                    if (data_wr)
                        pointer <= wr_data;
                end
                `FUNC_DATA: begin
                    pointer <= pointer;
                end
                `FUNC_DATA_INC_RW: begin
                    if (data_wr || data_rd)
                        pointer <= bump(pointer);
                end
                `FUNC_DATA_INC_WR: begin
                    if (data_wr)
                        pointer <= bump(pointer);
                end
                default: pointer <= pointer;
            endcase
        end
    end
end

// ==========================================================
// Extended register strobes and registered outputs
always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        o_ext_rd_stb <= 1'b0;
        o_ext_wr_stb <= 1'b0;
        o_ext_addr <= 16'h0000;
        o_ext_wr_data <= 16'h0000;
        o_mdio_out <= 1'b1;
        o_mdio_oe <= 1'b0;
    end else begin
        // Pointer is always presented so ext read data is ready
        // when the read frame samples it; controller must set it
        // up first, as the pointer after reset is only zero.
        o_ext_addr <= pointer;
        o_ext_rd_stb <= data_rd & target_ok &
            (func_sel != `FUNC_ADDRESS);
        o_ext_wr_stb <= data_wr & target_ok &
            (func_sel != `FUNC_ADDRESS);
        o_ext_wr_data <= wr_data;
        o_mdio_out <= frame_out;
        o_mdio_oe <= frame_oe;
    end
end

endmodule

/* tb/mdio_station.sv */
// Station manager model: drives MDC and MDIO frames for the bench.
// Assumes the bench resolves MDIO from the station drive and the device enable.
`timescale 1ns/1ps

module mdio_station (
    input wire logic i_clk,
    input wire logic i_mdio,
    output logic o_mdc,
    output logic o_mdio_drv
);
    // ==========================================
    // Bit and frame tasks
    initial begin
        o_mdc = 1'b0;
        o_mdio_drv = 1'b1;
    end

    // Three system cycles low and five high, above the two the slave needs
    task automatic clk_bit(input logic v, output logic s);
        @(posedge i_clk);
        o_mdc <= 1'b0;
        o_mdio_drv <= v;
        repeat (3) @(posedge i_clk);
        o_mdc <= 1'b1;
        // Sample mid-cycle, away from the edge that moves the line
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        s = i_mdio;
        @(posedge i_clk);
    endtask

    task automatic xfer(input logic rd, input logic [4:0] phy,
            input logic [4:0] ra, input logic [15:0] wd,
            output logic [15:0] rv);
        logic [63:0] f;
        logic s;
        f = {32'hFFFF_FFFF, 2'h1, rd ? 2'h2 : 2'h1, phy, ra,
             rd ? 2'h3 : 2'h2, rd ? 16'hFFFF : wd};
        rv = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            clk_bit(f[i], s);
            rv = {rv[14:0], s};
        end
        // Clock stands still and the line floats high between frames
        @(posedge i_clk);
        o_mdc <= 1'b0;
        o_mdio_drv <= 1'b1;
        repeat (16) @(posedge i_clk);
    endtask
endmodule

/* tb/phy_gig_status_properties.sv */
// Checker for the gigabit status bank, watching top-level ports only.
// Assumes MDC runs at eight system cycles per period.
`timescale 1ns/1ps

module phy_gig_status_properties (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic o_mdio_out,
    input wire logic o_mdio_oe,
    input wire logic o_ext_rd_stb,
    input wire logic o_ext_wr_stb,
    input wire logic [15:0] o_ext_addr
);
    // ==========================================
    // Sequences and properties
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    sequence drive_start;
        ##[1:40] $rose(o_mdio_oe);
    endsequence

    sequence drive_hold;
        o_mdio_oe [*8];
    endsequence

    chk_reset_idle: assert property ($fell(i_sys_rst) |->
        !o_mdio_oe && o_mdio_out && o_ext_addr == 16'h0000 && !o_ext_wr_stb)
        else $error("outputs not idle after reset");
    chk_wr_pulse: assert property (o_ext_wr_stb |=> !o_ext_wr_stb)
        else $error("write strobe wider than one cycle");
    chk_rd_pulse: assert property (o_ext_rd_stb |=> !o_ext_rd_stb)
        else $error("read strobe wider than one cycle");
    chk_strobe_excl: assert property (!(o_ext_rd_stb && o_ext_wr_stb))
        else $error("read and write strobes together");
    chk_rd_answer: assert property (o_ext_rd_stb |-> drive_start)
        else $error("extended read not answered on MDIO");
    chk_oe_hold: assert property ($rose(o_mdio_oe) |-> drive_hold)
        else $error("MDIO drive dropped early");
    chk_wr_quiet: assert property (o_ext_wr_stb |-> !o_mdio_oe)
        else $error("write strobe while driving MDIO");
    chk_idle_level: assert property (!o_mdio_oe |-> o_mdio_out)
        else $error("MDIO output not high while idle");
endmodule

/* tb/testbench.sv */
// Self-checking bench for the gigabit status and indirect access bank.
// Assumes the station model and the checker are compiled alongside.
`timescale 1ns/1ps
`include "phy_gig_status_regs.vh"

module testbench;
    // ==========================================
    // Signals and instances
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [4:0] phy = 5'h03;
    logic fault_ev = 1'b0;
    logic idle_ev = 1'b0;
    logic ms_master = 1'b0;
    logic local_ok = 1'b0;
    logic remote_ok = 1'b0;
    logic lp_fd = 1'b0;
    logic lp_hd = 1'b0;
    logic [15:0] ptr, junk, exp_wr, last_wd;
    logic [15:0] wr_cnt = 16'h0000;
    logic [15:0] rd_cnt = 16'h0000;
    logic [15:0] exp_rd = 16'h0000;
    logic [2:0] fn;
    wire mdc, drv, mdio_in, mdio_out, mdio_oe, ext_rd, ext_wr;
    wire [15:0] ext_addr, ext_wd, ext_rd_data;
    int fails = 0;
    int checks_done = 0;

    always #4 i_clk_sys = ~i_clk_sys;
    assign mdio_in = mdio_oe ? mdio_out : drv;
    // Extended store stand-in: content derived from the address
    assign ext_rd_data = ext_addr ^ 16'h5A5A;

    mdio_station mgr (.i_clk(i_clk_sys), .i_mdio(mdio_in), .o_mdc(mdc),
        .o_mdio_drv(drv));

    phy_gig_status_indirect_regs uut (.i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst), .i_mdc(mdc), .i_mdio_in(mdio_in),
        .i_phy_addr(phy), .i_ms_fault_event(fault_ev),
        .i_ms_resolved_master(ms_master), .i_local_rx_ok(local_ok),
        .i_remote_rx_ok(remote_ok), .i_lp_1000t_fd(lp_fd),
        .i_lp_1000t_hd(lp_hd), .i_idle_error_event(idle_ev),
        .i_ext_rd_data(ext_rd_data), .o_mdio_out(mdio_out),
        .o_mdio_oe(mdio_oe), .o_ext_rd_stb(ext_rd), .o_ext_wr_stb(ext_wr),
        .o_ext_addr(ext_addr), .o_ext_wr_data(ext_wd));

    always @(posedge i_clk_sys) begin
        if (ext_wr === 1'b1) begin
            wr_cnt <= wr_cnt + 16'h0001;
            last_wd <= ext_wd;
        end
        if (ext_rd === 1'b1)
            rd_cnt <= rd_cnt + 16'h0001;
    end

    // ==========================================
    // Access and check tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] x;
        mgr.xfer(1'b0, phy, ra, d, x);
    endtask

    task automatic rd_chk(input logic [4:0] ra, input logic [15:0] e);
        logic [15:0] x;
        mgr.xfer(1'b1, phy, ra, 16'h0000, x);
        check(x, e);
    endtask

    task automatic pulse(input int n, input logic flt);
        repeat (n) begin
            @(posedge i_clk_sys) {fault_ev, idle_ev} <= {flt, !flt};
            @(posedge i_clk_sys) {fault_ev, idle_ev} <= 2'h0;
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================
    // Tests
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        rd_chk(`IND_CTRL_ADDR, 16'h0000);
        rd_chk(`GIG_ABILITY_ADDR, 16'h3000);
        wr(`GIG_ABILITY_ADDR, 16'hFFFF);
        rd_chk(`GIG_ABILITY_ADDR, 16'h3000);
        $display("test reset_values done");
        for (int p = 0; p < 2; p++) begin
            @(posedge i_clk_sys)
                {ms_master, local_ok, remote_ok, lp_fd, lp_hd}
                    <= p ? 5'h15 : 5'h0A;
            rd_chk(`GIG_LINK_STATUS_ADDR,
                p ? 16'h5400 : 16'h2800);
        end
        wr(`GIG_LINK_STATUS_ADDR, 16'hFFFF);
        rd_chk(`GIG_LINK_STATUS_ADDR, 16'h5400);
        $display("test live_status done");
        pulse(1, 1'b1);
        pulse(3, 1'b0);
        repeat (40) @(posedge i_clk_sys);
        rd_chk(`GIG_LINK_STATUS_ADDR, 16'hD403);
        rd_chk(`GIG_LINK_STATUS_ADDR, 16'h5400);
        pulse(300, 1'b0);
        rd_chk(`GIG_LINK_STATUS_ADDR, 16'h54FF);
        // Fault held across the clearing read must survive it
        @(posedge i_clk_sys) fault_ev <= 1'b1;
        rd_chk(`GIG_LINK_STATUS_ADDR, 16'hD400);
        @(posedge i_clk_sys) fault_ev <= 1'b0;
        rd_chk(`GIG_LINK_STATUS_ADDR, 16'hD400);
        rd_chk(`GIG_LINK_STATUS_ADDR, 16'h5400);
        $display("test clear_on_read done");
        wr(`IND_CTRL_ADDR, 16'h3FFF);
        rd_chk(`IND_CTRL_ADDR, 16'h001F);
        mgr.xfer(1'b0, 5'h04, `IND_CTRL_ADDR, 16'h4005, junk);
        rd_chk(`IND_CTRL_ADDR, 16'h001F);
        // Read for another address: line must stay released high
        mgr.xfer(1'b1, 5'h04, `GIG_ABILITY_ADDR, 16'h0000, junk);
        check(junk, 16'hFFFF);
        wr(`IND_ADDR_DATA_ADDR, 16'h0040);
        rd_chk(`IND_ADDR_DATA_ADDR, 16'h0040);
        check(rd_cnt, exp_rd);
        ptr = 16'h0040;
        exp_wr = 16'h0000;
        for (fn = 3'h1; fn < 3'h4; fn++) begin
            wr(`IND_CTRL_ADDR, {fn[1:0], 14'h001F});
            wr(`IND_ADDR_DATA_ADDR, 16'hA500 ^ {14'h0000, fn[1:0]});
            exp_wr = exp_wr + 16'h0001;
            check(wr_cnt, exp_wr);
            check(last_wd, 16'hA500 ^ {14'h0000, fn[1:0]});
            if (fn[1])
                ptr = ptr + 16'h0001;
            check(ext_addr, ptr);
            rd_chk(`IND_ADDR_DATA_ADDR, ptr ^ 16'h5A5A);
            exp_rd = exp_rd + 16'h0001;
            check(rd_cnt, exp_rd);
            if (fn == 3'h2)
                ptr = ptr + 16'h0001;
            check(ext_addr, ptr);
        end
        wr(`IND_CTRL_ADDR, 16'h4005);
        wr(`IND_ADDR_DATA_ADDR, 16'h1234);
        rd_chk(`IND_ADDR_DATA_ADDR, 16'h0000);
        check(wr_cnt, exp_wr);
        check(rd_cnt, exp_rd);
        check(ext_addr, ptr);
        $display("test indirect done");
        give_verdict;
    end

    initial begin
        repeat (100000) @(posedge i_clk_sys);
        fails++;
        give_verdict;
    end
endmodule

bind phy_gig_status_indirect_regs phy_gig_status_properties chk (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .o_mdio_out(o_mdio_out),
    .o_mdio_oe(o_mdio_oe), .o_ext_rd_stb(o_ext_rd_stb),
    .o_ext_wr_stb(o_ext_wr_stb), .o_ext_addr(o_ext_addr));
